// ==== bench/sfa_feedback_model.sv ====
// Behavioural model of the speed sensors and the field current controller
`timescale 1ns/1ps
`default_nettype none
module sfa_feedback_model (
    input  wire logic        clk,
    input  wire logic        slowMode,
    input  wire logic [15:0] sensorDemand,
    input  wire logic [15:0] armatureDemand,
    input  wire logic [15:0] fieldDemand,
    input  wire logic        weakDemand,
    output logic      [15:0] sensorSpeed,
    output logic      [15:0] armatureSpeed,
    output logic      [15:0] fieldCurrent,
    output logic             weakRegion
);
    logic [15:0] sensorLag;

    // A filtered tacho lags the armature measurement, so slow mode adds a stage
    always_ff @(posedge clk) begin
        sensorLag <= sensorDemand;
        sensorSpeed <= slowMode ? sensorLag : sensorDemand;
        armatureSpeed <= armatureDemand;
        fieldCurrent <= fieldDemand;
        weakRegion <= weakDemand;
    end
endmodule : sfa_feedback_model
`default_nettype wire

// ==== bench/speed_fbk_field_loss_alarms_test.sv ====
// Self-checking bench for the speed feedback and field loss alarm block
`timescale 1ns/1ps
`default_nettype none
module speed_fbk_field_loss_alarms_test
    import sfa_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic [15:0] sensorDemand = 16'h1388, armatureDemand = 16'h1388, fieldDemand = 16'h1F40;
    logic        weakDemand = 1'b0, slowMode = 1'b0;
    logic [15:0] sensorSpeed, armatureSpeed, fieldCurrent;
    logic        weakRegion, driveTrip, useArmatureFeedback, mismatchWarningFlag, irq;
    logic        startCommand = 1'b0, inchRunCommand = 1'b0;
    int          nMismatch = 0;
    int          numChecks = 0;

    always #50 clk = ~clk;

    sfa_feedback_model model (.clk(clk), .slowMode(slowMode), .sensorDemand(sensorDemand),
        .armatureDemand(armatureDemand), .fieldDemand(fieldDemand), .weakDemand(weakDemand),
        .sensorSpeed(sensorSpeed), .armatureSpeed(armatureSpeed),
        .fieldCurrent(fieldCurrent), .weakRegion(weakRegion));

    // Short delays keep each alarm case to a few dozen cycles
    sfa_alarms #(.TRIP_DELAY(8), .FALLBACK_DELAY(4), .FIELD_DELAY(16)) dut (
        .clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sensorSpeed(sensorSpeed), .armatureSpeed(armatureSpeed),
        .fieldCurrent(fieldCurrent), .weakRegion(weakRegion), .startCommand(startCommand),
        .inchRunCommand(inchRunCommand), .driveTrip(driveTrip),
        .useArmatureFeedback(useArmatureFeedback), .mismatchWarningFlag(mismatchWarningFlag),
        .irq(irq));

    task automatic completeRun;
        if (nMismatch == 0 && numChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : completeRun

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic guard(input int n);
        if (n >= 50) begin
            nMismatch++;
            $display("mismatch bus_response expected answer seen none");
            completeRun();
        end
    endtask : guard

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 50);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        guard(n);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 50);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        guard(n);
    endtask : axi_read

    task automatic do_reset;
        reset <= 1'b1;
        sensorDemand <= 16'h1388;
        armatureDemand <= 16'h1388;
        fieldDemand <= 16'h1F40;
        weakDemand <= 1'b0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
    endtask : do_reset

    task automatic run_case(input logic [7:0] c, input logic [15:0] t, input logic [15:0] s,
                            input logic [15:0] a, input logic [15:0] f, input logic w,
                            input logic eT, input logic eF);
        do_reset();
        axi_write(ADDR_TOL, {16'h0000, t});
        axi_write(ADDR_CTRL, {24'h00_0000, c});
        sensorDemand <= s;
        armatureDemand <= a;
        fieldDemand <= f;
        weakDemand <= w;
        repeat (40) @(posedge clk);
        check("driveTrip", 32'(driveTrip), 32'(eT));
        check("useArmatureFeedback", 32'(useArmatureFeedback), 32'(eF));
    endtask : run_case

    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        axi_read(ADDR_CTRL);
        check("ctrl", rd, 32'h0000_0017);
        axi_read(ADDR_TOL);
        check("tol", rd, 32'h0000_1388);
        axi_write(ADDR_TOL, 32'h0000_4E20);
        axi_read(ADDR_TOL);
        check("tolMax", rd, 32'h0000_2710);
        axi_write(8'h14, 32'h0000_0001);
        check("writeResp", 32'(resp), 32'(RESP_SLVERR));
        axi_read(8'h14);
        check("readResp", 32'(resp), 32'(RESP_SLVERR));
        run_case(8'h07, 16'h03E8, 16'h0000, 16'h1388, 16'h1F40, 0, 0, 1);
        run_case(8'h17, 16'h03E8, 16'h0000, 16'h1388, 16'h1F40, 0, 1, 0);
        run_case(8'h16, 16'h03E8, 16'h0000, 16'h1388, 16'h1F40, 0, 0, 1);
        run_case(8'h17, 16'h05DC, 16'hFC18, 16'h03E8, 16'h1F40, 0, 1, 0);
        run_case(8'h16, 16'h05DC, 16'hFC18, 16'h03E8, 16'h1F40, 0, 0, 1);
        run_case(8'h16, 16'h1388, 16'hFC18, 16'h03E8, 16'h1F40, 0, 1, 0);
        run_case(8'h1E, 16'h1388, 16'hFC18, 16'h03E8, 16'h1F40, 0, 1, 0);
        run_case(8'h1E, 16'h1388, 16'h01F4, 16'h1388, 16'h1F40, 1, 1, 0);
        run_case(8'h1F, 16'h1388, 16'h0BB8, 16'h1388, 16'h1F40, 1, 0, 0);
        run_case(8'h0E, 16'h1388, 16'h1388, 16'h1388, 16'h1F40, 1, 1, 1);
        run_case(8'h37, 16'h03E8, 16'h0000, 16'h1388, 16'h1F40, 0, 1, 0);
        run_case(8'h46, 16'h03E8, 16'h0000, 16'h1388, 16'h1F40, 0, 0, 1);
        run_case(8'h46, 16'h05DC, 16'hFC18, 16'h03E8, 16'h1F40, 0, 0, 1);
        run_case(8'h46, 16'h1388, 16'hFC18, 16'h03E8, 16'h1F40, 0, 1, 0);
        run_case(8'h1E, 16'h1388, 16'h1388, 16'h1388, 16'h03E8, 1, 0, 0);
        run_case(8'h12, 16'h1388, 16'h1388, 16'h1388, 16'h0000, 0, 0, 0);
        run_case(8'h14, 16'h1388, 16'h1388, 16'h1388, 16'h0000, 0, 0, 0);
        // Fallback with a lagging sensor, interrupt masking and clearing
        slowMode <= 1'b1;
        run_case(8'h16, 16'h03E8, 16'h0000, 16'h1388, 16'h1F40, 0, 0, 1);
        // Mismatch must be gone well before the clear, or the warning set wins over it
        sensorDemand <= 16'h1388;
        axi_write(ADDR_IRQ_MASK, 32'h0000_000F);
        repeat (3) @(posedge clk);
        check("irqUnmasked", 32'(irq), 32'h0000_0001);
        axi_write(ADDR_IRQ_MASK, 32'h0000_0000);
        repeat (3) @(posedge clk);
        check("irqMasked", 32'(irq), 32'h0000_0000);
        axi_write(ADDR_IRQ_MASK, 32'h0000_000F);
        axi_write(ADDR_IRQ_STAT, 32'h0000_000F);
        repeat (4) @(posedge clk);
        check("irqCleared", 32'(irq), 32'h0000_0000);
        check("fallbackHeld", 32'(useArmatureFeedback), 32'h0000_0001);
        startCommand <= 1'b1;
        repeat (8) @(posedge clk);
        check("sourceRestored", 32'(useArmatureFeedback), 32'h0000_0000);
        startCommand <= 1'b0;
        // Warning flag, latched state and clearing by an inch run
        run_case(8'h17, 16'h03E8, 16'h0000, 16'h1388, 16'h1F40, 0, 1, 0);
        check("warning", 32'(mismatchWarningFlag), 32'h0000_0001);
        axi_read(ADDR_STATE);
        check("state", rd, 32'h0000_004B);
        sensorDemand <= 16'h1388;
        // Let the restored speed pass the pin pipeline so the inch edge is not beaten by a set
        repeat (6) @(posedge clk);
        inchRunCommand <= 1'b1;
        repeat (8) @(posedge clk);
        check("warningCleared", 32'(mismatchWarningFlag), 32'h0000_0000);
        check("tripLatched", 32'(driveTrip), 32'h0000_0001);
        inchRunCommand <= 1'b0;
        axi_write(ADDR_CTRL, 32'h0000_0117);
        repeat (2) @(posedge clk);
        check("tripReset", 32'(driveTrip), 32'h0000_0000);
        axi_read(ADDR_CTRL);
        check("ctrlPulseBit", rd, 32'h0000_0017);
        // Field dips shorter than the delay must never add up to a trip
        run_case(8'h16, 16'h1388, 16'h1388, 16'h1388, 16'h1F40, 0, 0, 0);
        repeat (3) begin
            fieldDemand <= 16'h05DC;
            repeat (12) @(posedge clk);
            fieldDemand <= 16'h1F40;
            repeat (4) @(posedge clk);
        end
        check("fieldDips", 32'(driveTrip), 32'h0000_0000);
        fieldDemand <= 16'h05DC;
        repeat (40) @(posedge clk);
        check("fieldLoss", 32'(driveTrip), 32'h0000_0001);
        completeRun();
    end
endmodule : speed_fbk_field_loss_alarms_test
`default_nettype wire

// ==== logic/sfa_alarms.sv ====
// Speed feedback mismatch and field loss alarms with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module sfa_alarms
    import sfa_pkg::*;
#(
    parameter int TRIP_DELAY     = TRIP_CYCLES,
    parameter int FALLBACK_DELAY = FALLBACK_CYCLES,
    parameter int FIELD_DELAY    = FIELD_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [15:0] sensorSpeed,
    input  wire logic [15:0] armatureSpeed,
    input  wire logic [15:0] fieldCurrent,
    input  wire logic        weakRegion,
    input  wire logic        startCommand,
    input  wire logic        inchRunCommand,
    output logic             driveTrip,
    output logic             useArmatureFeedback,
    output logic             mismatchWarningFlag,
    output logic             irq
);
    logic [50:0] pinMeta;
    logic [50:0] pinSync;
    logic [31:0] ctrl;
    logic [15:0] mismatchTolerance;
    logic [3:0]  irqStatus;
    logic [3:0]  irqMask;
    logic        mismatchTripLatched;
    logic        fallbackActive;
    logic        fieldTripLatched;
    logic        startPrev;
    logic        inchPrev;
    logic [31:0] wAddrData;
    logic [7:0]  wAddr;
    logic [3:0]  wStrb;
    logic [3:0]  cond;
    logic [3:0]  timerDone;
    logic        tripCond;
    logic        fallCond;
    logic [16:0] speedDiff;
    logic [16:0] absDiff;
    logic [15:0] absSensor;
    logic        reversed;
    logic        mismatch;
    logic        totalLoss;
    logic        fieldLow;
    logic        startRise;
    logic        inchRise;
    logic        doWrite;
    logic        tripReset;
    logic [31:0] stateWord;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    sfa_source_t source;

    wire logic [15:0] sSensor   = pinSync[15:0];
    wire logic [15:0] sArmature = pinSync[31:16];
    wire logic [15:0] sField    = pinSync[47:32];
    wire logic        sWeak     = pinSync[48];
    wire logic        sStart    = pinSync[49];
    wire logic        sInch     = pinSync[50];
    wire logic        tripOn    = ctrl[CTRL_MISMATCH_TRIP_ON];
    wire logic        weakOn    = ctrl[CTRL_FIELD_WEAK_ON];
    wire logic        avOnly    = (source == SRC_ARMATURE);

    // Measurements arrive from the converters on their own timing, so the measurement and command pins are synchronised
    always_ff @(posedge clk) begin
        if (reset) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= {inchRunCommand, startCommand, weakRegion, fieldCurrent,
                        armatureSpeed, sensorSpeed};
            pinSync <= pinMeta;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            startPrev <= 1'b0;
            inchPrev  <= 1'b0;
        end else begin
            startPrev <= sStart;
            inchPrev  <= sInch;
        end
    end
    assign startRise = sStart && !startPrev;
    assign inchRise  = sInch && !inchPrev;

    always_comb begin
        case (ctrl[CTRL_SOURCE_LSB +: 3])
            3'b001:  source = SRC_TACHO;
            3'b010:  source = SRC_ENCODER;
            3'b011:  source = SRC_ENC_ARM;
            3'b100:  source = SRC_ENC_TACHO;
            default: source = SRC_ARMATURE;
        endcase
    end

    // Speeds are signed, in 0.01 percent of full speed
    assign speedDiff = {sSensor[15], sSensor} - {sArmature[15], sArmature};
    assign absDiff   = speedDiff[16] ? 17'(-speedDiff) : speedDiff;
    assign absSensor = sSensor[15] ? 16'(-sSensor) : sSensor;
    assign mismatch  = absDiff > {1'b0, mismatchTolerance};
    assign reversed  = (sSensor[15] != sArmature[15]) && (sSensor != '0) && (sArmature != '0);
    assign totalLoss = absSensor < TOTAL_LOSS_LEVEL;
    assign fieldLow  = sField < (sWeak ? FIELD_LOSS_WEAK : FIELD_LOSS_NORM);

    // Fault judgement by source, polarity, severity and weakening state
    always_comb begin
        tripCond = 1'b0;
        fallCond = 1'b0;
        if (weakOn) begin
            if (avOnly || source == SRC_ENC_ARM) begin
                tripCond = sWeak;
            end
            if (!avOnly && (reversed || (totalLoss && sWeak))) begin
                tripCond = 1'b1;
            end
        end else if (!avOnly && !fallbackActive) begin
            if (reversed) begin
                if (mismatchTolerance > POLARITY_TOL || tripOn) begin
                    tripCond = 1'b1;
                end else begin
                    fallCond = 1'b1;
                end
            end else if (mismatch) begin
                tripCond = tripOn;
                fallCond = !tripOn;
            end
        end
    end

    assign cond[0] = tripCond;
    assign cond[1] = fallCond;
    assign cond[2] = fieldLow && ctrl[CTRL_FIELD_SUPPLY_ON];
    assign cond[3] = mismatch && !avOnly && !(weakOn && sWeak);

    genvar g;
    for (g = 0; g < 4; g++) begin : gTimer
        localparam logic [TIMER_W-1:0] LIM = TIMER_W'(g == 1 ? FALLBACK_DELAY :
                                                     g == 2 ? FIELD_DELAY : TRIP_DELAY);
        logic [TIMER_W-1:0] cnt;
        always_ff @(posedge clk) begin
            if (reset || !cond[g]) begin
                cnt <= '0;
            end else if (cnt != LIM) begin
                cnt <= cnt + 1'b1;
            end
        end
        assign timerDone[g] = cond[g] && (cnt == LIM);
    end

    // Latched alarm state; a new set beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            mismatchTripLatched <= 1'b0;
            fieldTripLatched    <= 1'b0;
        end else begin
            mismatchTripLatched <= timerDone[0] || (mismatchTripLatched && !tripReset);
            fieldTripLatched    <= (timerDone[2] && ctrl[CTRL_FIELD_TRIP_ON])
                                   || (fieldTripLatched && !tripReset);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fallbackActive      <= 1'b0;
            mismatchWarningFlag <= 1'b0;
        end else begin
            fallbackActive      <= timerDone[1] || (fallbackActive && !startRise);
            mismatchWarningFlag <= timerDone[3]
                                   || (mismatchWarningFlag && !startRise && !inchRise);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            driveTrip           <= 1'b0;
            useArmatureFeedback <= 1'b0;
            irq                 <= 1'b0;
        end else begin
            driveTrip           <= mismatchTripLatched || fieldTripLatched;
            useArmatureFeedback <= avOnly || fallbackActive;
            irq                 <= |(irqStatus & irqMask);
        end
    end

    // AXI4-Lite write path: address and data taken in either order
    assign doWrite   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign tripReset = doWrite && wAddr == ADDR_CTRL && wStrb[1]
                       && wAddrData[CTRL_TRIP_RESET];

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            wAddr         <= '0;
            wAddrData     <= '0;
            wStrb         <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wAddr         <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                // Lanes travel with the data: the master may move wstrb once W is taken
                wAddrData    <= s_axi_wdata;
                wStrb        <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wAddr <= ADDR_IRQ_MASK && wAddr[1:0] == 2'b00)
                                ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Only the low byte lanes carry fields; the trip reset bit never stores
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl              <= CTRL_RESET;
            mismatchTolerance <= TOL_RESET;
            irqMask           <= '0;
        end else if (doWrite) begin
            if (wAddr == ADDR_CTRL && wStrb[0]) begin
                ctrl <= {24'h00_0000, 1'b0, wAddrData[6:0]};
            end
            if (wAddr == ADDR_TOL && wStrb[1:0] == 2'b11) begin
                // Out of range values saturate rather than being refused
                mismatchTolerance <= (wAddrData[15:0] > TOL_MAX) ? TOL_MAX
                                     : wAddrData[15:0];
            end
            if (wAddr == ADDR_IRQ_MASK && wStrb[0]) begin
                irqMask <= wAddrData[3:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irqStatus <= '0;
        end else begin
            irqStatus <= ((doWrite && wAddr == ADDR_IRQ_STAT && wStrb[0])
                          ? irqStatus & ~wAddrData[3:0] : irqStatus)
                         | {timerDone[3], timerDone[2] && ctrl[CTRL_FIELD_TRIP_ON],
                            timerDone[1], timerDone[0]};
        end
    end

    // AXI4-Lite read path
    assign stateWord = {25'h000_0000, driveTrip, fieldTripLatched, cond[2],
                        mismatchWarningFlag, fallbackActive, mismatchTripLatched, cond[3]};

    always_comb begin
        next_rresp = RESP_OKAY;
        case (s_axi_araddr)
            ADDR_CTRL:     next_rdata = ctrl;
            ADDR_TOL:      next_rdata = {16'h0000, mismatchTolerance};
            ADDR_STATE:    next_rdata = stateWord;
            ADDR_IRQ_STAT: next_rdata = {28'h000_0000, irqStatus};
            ADDR_IRQ_MASK: next_rdata = {28'h000_0000, irqMask};
            default: begin
                next_rdata = '0;
                next_rresp = RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_av_only_quiet: assert property (avOnly && !weakOn |-> !tripCond && !fallCond)
        else $error("mismatch judged with armature-only feedback");
    a_polarity_high_tol: assert property (!weakOn && !avOnly && !fallbackActive && reversed
        && mismatchTolerance > POLARITY_TOL |-> tripCond)
        else $error("reversed polarity above 20 percent did not trip");
    a_polarity_low_tol: assert property (!weakOn && !avOnly && !fallbackActive && reversed
        && mismatchTolerance <= POLARITY_TOL && !tripOn |-> fallCond && !tripCond)
        else $error("reversed polarity with trip off did not fall back");
    a_loss_fallback: assert property (!weakOn && !avOnly && !fallbackActive && !reversed
        && mismatch |-> (tripCond == tripOn) && (fallCond == !tripOn))
        else $error("feedback loss judged wrongly");
    a_weak_entry_trip: assert property (weakOn && avOnly && sWeak |-> tripCond)
        else $error("armature-only feedback in weakening did not trip");
    a_weak_partial: assert property (weakOn && !avOnly && !reversed && !totalLoss
        && source != SRC_ENC_ARM |-> !tripCond && !fallCond)
        else $error("partial loss during weakening gave a mismatch action");
    a_trip_latch_cause: assert property ($rose(mismatchTripLatched)
        |-> $past(timerDone[0]))
        else $error("mismatch trip latched without its delay");
    a_drive_trip_follow: assert property (mismatchTripLatched || fieldTripLatched
        |=> driveTrip)
        else $error("latched alarm did not trip the drive");
    a_timer_restart: assert property (!cond[0] |=> gTimer[0].cnt == '0)
        else $error("trip timer not restarted");
    a_field_inhibit: assert property (!ctrl[CTRL_FIELD_SUPPLY_ON]
        |=> !$rose(fieldTripLatched))
        else $error("field loss alarm with field supply disabled");
    a_warn_clear: assert property (mismatchWarningFlag && !timerDone[3]
        && (startRise || inchRise) |=> !mismatchWarningFlag)
        else $error("warning flag not cleared by start or inch");
    a_fallback_hold: assert property (fallbackActive && !startRise
        |=> fallbackActive)
        else $error("fallback released without a start");
    a_tol_range: assert property (mismatchTolerance <= TOL_MAX)
        else $error("tolerance out of range");

    c_trip: cover property ($rose(driveTrip));
    c_fallback: cover property ($rose(fallbackActive));
    c_field_trip: cover property ($rose(fieldTripLatched));
    c_warn_clear: cover property ($fell(mismatchWarningFlag));
endmodule : sfa_alarms
`default_nettype wire

// ==== logic/sfa_pkg.sv ====
// Constants and types for the speed feedback and field loss alarm block
package sfa_pkg;
    // Register byte addresses
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_TOL      = 8'h04;
    localparam logic [7:0]  ADDR_STATE    = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_MASK = 8'h10;

    // Control register fields
    localparam int          CTRL_MISMATCH_TRIP_ON = 0;
    localparam int          CTRL_FIELD_TRIP_ON    = 1;
    localparam int          CTRL_FIELD_SUPPLY_ON  = 2;
    localparam int          CTRL_FIELD_WEAK_ON    = 3;
    localparam int          CTRL_SOURCE_LSB       = 4;
    localparam int          CTRL_TRIP_RESET       = 8;
    localparam logic [31:0] CTRL_RESET            = 32'h0000_0017;

    // Status and interrupt bit positions
    localparam int          ST_MISMATCH_ACTIVE = 0;
    localparam int          ST_MISMATCH_TRIP   = 1;
    localparam int          ST_FALLBACK        = 2;
    localparam int          ST_WARNING         = 3;
    localparam int          ST_FIELD_ACTIVE    = 4;
    localparam int          ST_FIELD_TRIP      = 5;
    localparam int          ST_DRIVE_TRIP      = 6;
    localparam int          IRQ_MISMATCH_TRIP  = 0;
    localparam int          IRQ_FALLBACK       = 1;
    localparam int          IRQ_FIELD_TRIP     = 2;
    localparam int          IRQ_WARNING        = 3;

    // Levels in units of 0.01 percent
    localparam logic [15:0] TOL_MAX          = 16'h2710;
    localparam logic [15:0] TOL_RESET        = 16'h1388;
    localparam logic [15:0] POLARITY_TOL     = 16'h07D0;
    localparam logic [15:0] TOTAL_LOSS_LEVEL = 16'h03E8;
    localparam logic [15:0] FIELD_LOSS_NORM  = 16'h07D0;
    localparam logic [15:0] FIELD_LOSS_WEAK  = 16'h01F4;

    // Alarm delays
    localparam int          CLK_HZ            = 10_000_000;
    localparam int          TRIP_DELAY_MS     = 400;
    localparam int          FALLBACK_DELAY_MS = 200;
    localparam int          FIELD_DELAY_MS    = 2000;
    localparam int          TRIP_CYCLES       = CLK_HZ / 1000 * TRIP_DELAY_MS;
    localparam int          FALLBACK_CYCLES   = CLK_HZ / 1000 * FALLBACK_DELAY_MS;
    localparam int          FIELD_CYCLES      = CLK_HZ / 1000 * FIELD_DELAY_MS;
    localparam int          TIMER_W           = 25;

    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        SRC_ARMATURE  = 3'b000,
        SRC_TACHO     = 3'b001,
        SRC_ENCODER   = 3'b010,
        SRC_ENC_ARM   = 3'b011,
        SRC_ENC_TACHO = 3'b100
    } sfa_source_t;
endpackage : sfa_pkg
